/* common/otp_prog_map.vh */
`ifndef OTP_PROG_MAP_VH
`define OTP_PROG_MAP_VH
`define CLK_MHZ 16'h00FA
`define PULSE_NOM_US 16'h0064
`define PULSE_CYC (`PULSE_NOM_US * `CLK_MHZ)
`define SETUP_US 16'h0002
`define SETUP_CYC (`SETUP_US * `CLK_MHZ)
`define OE_READ_NS 16'h0096
`define OE_READ_CYC ((`OE_READ_NS * `CLK_MHZ + 16'h03E7) / 16'h03E8)
`define FLOAT_NS 16'h0082
`define FLOAT_CYC ((`FLOAT_NS * `CLK_MHZ + 16'h03E7) / 16'h03E8)
`define MAX_RETRY 4'hA
`define ADDR_W 16
`define DATA_W 16
`define ADDR_FIRST 16'h0000
`define ADDR_LAST 16'hFFFF
`define ID_ADDR_MFR 16'h0000
`define ID_ADDR_DEV 16'h0001
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define CNT_W 16
`endif

/* rtl/otp_program_host.v */
`timescale 1ns/10ps
`include "otp_prog_map.vh"
module otp_program_host (
	// Clock, reset and enable.
	input wire CLK,
	input wire SYS_RST,
	input wire CE,
	// Commands.
	input wire START_PROG,
	input wire START_ID,
	input wire [`ADDR_W-1:0] LAST_ADDR,
	// Source words, one per address in order.
	input wire [`DATA_W-1:0] SRC_DATA,
	input wire SRC_VALID,
	output wire SRC_READY,
	// Memory pins.
	output reg [`ADDR_W-1:0] MEM_ADDR,
	output reg [`DATA_W-1:0] MEM_DQ_OUT,
	output reg MEM_DQ_OE_N,
	input wire [`DATA_W-1:0] MEM_DQ_IN,
	output reg CHIP_SEL_N,
	output reg OUT_SEL_N,
	output reg PROGRAM_STROBE_N,
	output reg VCC_HIGH,
	output reg VPP_HIGH,
	output reg ID_MODE_ADDRESS_BIT,
	// Status.
	output reg BUSY,
	output reg DONE,
	output reg PASS,
	output reg FAIL,
	output reg [`DATA_W-1:0] MFR_CODE,
	output reg [`DATA_W-1:0] DEV_CODE
);
	localparam S_IDLE = 4'h0;
	localparam S_PWR = 4'h1;
	localparam S_LOAD = 4'h2;
	localparam S_PULSE = 4'h3;
	localparam S_GAP = 4'h4;
	localparam S_VRD = 4'h5;
	localparam S_VCMP = 4'h6;
	localparam S_LOW = 4'h7;
	localparam S_RLOAD = 4'h8;
	localparam S_RRD = 4'h9;
	localparam S_IDRD = 4'hA;
	localparam S_END = 4'hB;

	reg [3:0] st_q;
	reg [`CNT_W-1:0] tmr_q;
	reg [3:0] retry_q;
	reg first_q;
	reg [`DATA_W-1:0] word_q;
	reg src_pop;
	wire [`DATA_W-1:0] f_data;
	wire f_valid;
	wire tdone = (tmr_q == {`CNT_W{1'b0}});
	wire last = (MEM_ADDR == LAST_ADDR);

	// The FIFO lets the source run ahead by a few words, hiding its own latency per address.
	word_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) src_fifo (
		.clk(CLK),
		.rst(SYS_RST),
		.ce(CE),
		.in_data(SRC_DATA),
		.in_valid(SRC_VALID),
		.in_ready(SRC_READY),
		.out_data(f_data),
		.out_valid(f_valid),
		.out_ready(src_pop)
	);

	always @* begin
		src_pop = CE && f_valid && (st_q == S_LOAD || st_q == S_RLOAD);
	end

	always @(posedge CLK) begin
		if (SYS_RST) begin
			st_q <= S_IDLE;
			tmr_q <= {`CNT_W{1'b0}};
			retry_q <= 4'h0;
			first_q <= 1'b0;
			word_q <= {`DATA_W{1'b0}};
			MEM_ADDR <= `ADDR_FIRST;
			MEM_DQ_OUT <= {`DATA_W{1'b0}};
			MEM_DQ_OE_N <= 1'b1;
			CHIP_SEL_N <= 1'b1;
			OUT_SEL_N <= 1'b1;
			PROGRAM_STROBE_N <= 1'b1;
			VCC_HIGH <= 1'b0;
			VPP_HIGH <= 1'b0;
			ID_MODE_ADDRESS_BIT <= 1'b0;
			BUSY <= 1'b0;
			DONE <= 1'b0;
			PASS <= 1'b0;
			FAIL <= 1'b0;
			MFR_CODE <= {`DATA_W{1'b0}};
			DEV_CODE <= {`DATA_W{1'b0}};
		end else if (CE) begin
			if (!tdone) begin
				tmr_q <= tmr_q - 1'b1;
			end
			case (st_q)
			S_IDLE: begin
				if (START_PROG) begin
					BUSY <= 1'b1;
					DONE <= 1'b0;
					PASS <= 1'b0;
					FAIL <= 1'b0;
					VCC_HIGH <= 1'b1;
					VPP_HIGH <= 1'b1;
					MEM_ADDR <= `ADDR_FIRST;
					tmr_q <= `SETUP_CYC;
					st_q <= S_PWR;
				end else if (START_ID) begin
					BUSY <= 1'b1;
					DONE <= 1'b0;
					ID_MODE_ADDRESS_BIT <= 1'b1;
					MEM_ADDR <= `ID_ADDR_MFR;
					CHIP_SEL_N <= 1'b0;
					OUT_SEL_N <= 1'b0;
					tmr_q <= `SETUP_CYC;
					first_q <= 1'b1;
					st_q <= S_IDRD;
				end
			end
			S_PWR: begin
				if (tdone) begin
					st_q <= S_LOAD;
				end
			end
			S_LOAD: begin
				if (f_valid) begin
					word_q <= f_data;
					MEM_DQ_OUT <= f_data;
					MEM_DQ_OE_N <= 1'b0;
					CHIP_SEL_N <= 1'b0;
					OUT_SEL_N <= 1'b1;
					retry_q <= 4'h0;
					first_q <= 1'b1;
					tmr_q <= `SETUP_CYC;
					st_q <= S_GAP;
				end
			end
			S_GAP: begin
				// Setup before a pulse, also used as float time after a verify read.
				if (tdone) begin
					PROGRAM_STROBE_N <= 1'b0;
					tmr_q <= `PULSE_CYC - 16'h0001;
					st_q <= S_PULSE;
				end
			end
			S_PULSE: begin
				if (tdone) begin
					PROGRAM_STROBE_N <= 1'b1;
					// Data stays driven through the hold time after the strobe rises.
					tmr_q <= `SETUP_CYC;
					st_q <= S_VRD;
				end
			end
			S_VRD: begin
				// After the data hold, open the outputs; the first pulse skips this.
				if (tdone) begin
					if (first_q) begin
						first_q <= 1'b0;
						MEM_DQ_OE_N <= 1'b0;
						tmr_q <= `SETUP_CYC;
						st_q <= S_GAP;
					end else begin
						OUT_SEL_N <= 1'b0;
						MEM_DQ_OE_N <= 1'b1;
						tmr_q <= `OE_READ_CYC;
						st_q <= S_VCMP;
					end
				end
			end
			S_VCMP: begin
				if (tdone) begin
					OUT_SEL_N <= 1'b1;
					if (MEM_DQ_IN == word_q) begin
						if (last) begin
							VCC_HIGH <= 1'b0;
							VPP_HIGH <= 1'b0;
							CHIP_SEL_N <= 1'b1;
							MEM_ADDR <= `ADDR_FIRST;
							tmr_q <= `SETUP_CYC;
							st_q <= S_LOW;
						end else begin
							MEM_ADDR <= MEM_ADDR + 1'b1;
							retry_q <= 4'h0;
							st_q <= S_LOAD;
						end
					end else if (retry_q == `MAX_RETRY - 4'h1) begin
						// Retry count zero is the first of the ten verified pulses.
						FAIL <= 1'b1;
						VCC_HIGH <= 1'b0;
						VPP_HIGH <= 1'b0;
						CHIP_SEL_N <= 1'b1;
						st_q <= S_END;
					end else begin
						retry_q <= retry_q + 1'b1;
						MEM_DQ_OE_N <= 1'b0;
						tmr_q <= `FLOAT_CYC + `SETUP_CYC;
						st_q <= S_GAP;
					end
				end
			end
			S_LOW: begin
				// Read-back needs the source replayed from the first word.
				if (tdone) begin
					st_q <= S_RLOAD;
				end
			end
			S_RLOAD: begin
				if (f_valid) begin
					word_q <= f_data;
					CHIP_SEL_N <= 1'b0;
					OUT_SEL_N <= 1'b0;
					tmr_q <= `OE_READ_CYC;
					st_q <= S_RRD;
				end
			end
			S_RRD: begin
				if (tdone) begin
					if (MEM_DQ_IN != word_q) begin
						FAIL <= 1'b1;
						CHIP_SEL_N <= 1'b1;
						OUT_SEL_N <= 1'b1;
						st_q <= S_END;
					end else if (last) begin
						PASS <= 1'b1;
						CHIP_SEL_N <= 1'b1;
						OUT_SEL_N <= 1'b1;
						st_q <= S_END;
					end else begin
						MEM_ADDR <= MEM_ADDR + 1'b1;
						st_q <= S_RLOAD;
					end
				end
			end
			S_IDRD: begin
				if (tdone) begin
					if (first_q) begin
						MFR_CODE <= MEM_DQ_IN;
						first_q <= 1'b0;
						MEM_ADDR <= `ID_ADDR_DEV;
						tmr_q <= `SETUP_CYC;
					end else begin
						DEV_CODE <= MEM_DQ_IN;
						ID_MODE_ADDRESS_BIT <= 1'b0;
						CHIP_SEL_N <= 1'b1;
						OUT_SEL_N <= 1'b1;
						MEM_ADDR <= `ADDR_FIRST;
						st_q <= S_END;
					end
				end
			end
			S_END: begin
				BUSY <= 1'b0;
				DONE <= 1'b1;
				MEM_DQ_OE_N <= 1'b1;
				st_q <= S_IDLE;
			end
			default: begin
				st_q <= S_IDLE;
			end
			endcase
		end
	end
endmodule

/* rtl/word_fifo.v */
`timescale 1ns/10ps
module word_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 4,
	parameter AW = 2
) (
	input wire clk,
	input wire rst,
	input wire ce,
	input wire [WIDTH-1:0] in_data,
	input wire in_valid,
	output wire in_ready,
	output wire [WIDTH-1:0] out_data,
	output wire out_valid,
	input wire out_ready
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	reg [AW:0] cnt_d;
	reg in_ready_q;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;
	// Ready is registered from the next count so that it leaves the block straight from a flop.
	assign in_ready = in_ready_q;
	assign out_valid = (cnt_q != {(AW+1){1'b0}});
	assign out_data = mem[rd_q];
	always @* begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end
	always @(posedge clk) begin
		if (rst) begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			in_ready_q <= 1'b1;
		end else if (ce) begin
			cnt_q <= cnt_d;
			in_ready_q <= (cnt_d != DEPTH[AW:0]);
			if (push) begin
				mem[wr_q] <= in_data;
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

/* verification/otp_device_model.sv */
`timescale 1ns/10ps
// Both code values are arbitrary.
module otp_device_model #(
	parameter [15:0] MFR_ID = 16'h005A,
	parameter [15:0] DEV_ID = 16'h00C3
) (
	input wire CLK,
	input wire [15:0] MEM_ADDR,
	input wire [15:0] MEM_DQ_OUT,
	input wire MEM_DQ_OE_N,
	output reg [15:0] MEM_DQ_IN,
	input wire CHIP_SEL_N,
	input wire OUT_SEL_N,
	input wire PROGRAM_STROBE_N,
	input wire VPP_HIGH,
	input wire ID_MODE_ADDRESS_BIT
);
	reg [15:0] mem [0:3];
	initial begin
		MEM_DQ_IN = 16'h0000;
		mem[0] = 16'hFFFF;
	end
	// Programming only clears bits, so a bad word cannot be repaired.
	always @(posedge PROGRAM_STROBE_N) if (!CHIP_SEL_N && !MEM_DQ_OE_N && VPP_HIGH)
		mem[MEM_ADDR[1:0]] <= mem[MEM_ADDR[1:0]] & MEM_DQ_OUT;
	// Released bus toggles every cycle so a stale value never looks valid.
	always @(posedge CLK) begin
		if (!CHIP_SEL_N && !OUT_SEL_N && PROGRAM_STROBE_N)
			MEM_DQ_IN <= ID_MODE_ADDRESS_BIT ? (MEM_ADDR[0] ? DEV_ID : MFR_ID) : mem[MEM_ADDR[1:0]];
		else
			MEM_DQ_IN <= ~MEM_DQ_IN;
	end
endmodule

/* verification/otp_host_properties.sv */
`timescale 1ns/10ps
module otp_host_checker (
	// Clock and reset.
	input wire CLK,
	input wire SYS_RST,
	// Memory pins.
	input wire [15:0] MEM_ADDR,
	input wire MEM_DQ_OE_N,
	input wire CHIP_SEL_N,
	input wire OUT_SEL_N,
	input wire PROGRAM_STROBE_N,
	input wire VCC_HIGH,
	input wire VPP_HIGH,
	input wire ID_MODE_ADDRESS_BIT,
	// Status.
	input wire DONE,
	input wire PASS,
	input wire FAIL
);
	reg [15:0] low_q;
	always @(posedge CLK) low_q <= (SYS_RST || PROGRAM_STROBE_N) ? 16'h0000 : low_q + 16'h0001;
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	property p_pulse_width;
		$rose(PROGRAM_STROBE_N) |-> low_q >= 16'h5CC6 && low_q <= 16'h668A;
	endproperty
	a_pulse_width: assert property (p_pulse_width) else $error("strobe width");
	property p_supply; !PROGRAM_STROBE_N |-> VCC_HIGH && VPP_HIGH; endproperty
	a_supply: assert property (p_supply) else $error("supply low in pulse");
	property p_vcc_first; $rose(VPP_HIGH) |-> VCC_HIGH; endproperty
	a_vcc_first: assert property (p_vcc_first) else $error("vpp before vcc");
	property p_first_addr; $rose(VCC_HIGH) |=> MEM_ADDR == 16'h0000; endproperty
	a_first_addr: assert property (p_first_addr) else $error("start address");
	property p_verify; !OUT_SEL_N |-> PROGRAM_STROBE_N && MEM_DQ_OE_N && !CHIP_SEL_N; endproperty
	a_verify: assert property (p_verify) else $error("verify read pins");
	property p_id_mode; ID_MODE_ADDRESS_BIT |-> PROGRAM_STROBE_N && !VPP_HIGH; endproperty
	a_id_mode: assert property (p_id_mode) else $error("id mode pins");
	property p_fail; $rose(FAIL) |=> DONE && !PASS; endproperty
	a_fail: assert property (p_fail) else $error("fail verdict");
	property p_readback; $rose(PASS) |-> !VCC_HIGH && !VPP_HIGH; endproperty
	a_readback: assert property (p_readback) else $error("supplies not nominal");
	c_id: cover property ($rose(ID_MODE_ADDRESS_BIT));
	c_pulse: cover property ($rose(PROGRAM_STROBE_N));
	c_pass: cover property ($rose(PASS));
endmodule
bind otp_program_host otp_host_checker i_chk (.CLK(CLK), .SYS_RST(SYS_RST),
	.MEM_ADDR(MEM_ADDR), .MEM_DQ_OE_N(MEM_DQ_OE_N), .CHIP_SEL_N(CHIP_SEL_N),
	.OUT_SEL_N(OUT_SEL_N), .PROGRAM_STROBE_N(PROGRAM_STROBE_N), .VCC_HIGH(VCC_HIGH),
	.VPP_HIGH(VPP_HIGH), .ID_MODE_ADDRESS_BIT(ID_MODE_ADDRESS_BIT), .DONE(DONE),
	.PASS(PASS), .FAIL(FAIL));

/* verification/otp_program_host_tb.sv */
`timescale 1ns/10ps
module otp_program_host_tb;
	reg clk = 1'b0, rst = 1'b1, start_prog = 1'b0, start_id = 1'b0, src_valid = 1'b0, ce = 1'b1;
	reg [15:0] src_data = 16'h0000;
	integer failures = 0, n_checks = 0, seed = 64, k, rnd;
	reg [32:0] notes [$];
	reg [32:0] note;
	wire [15:0] addr, dq_out, dq_in, mfr, dev;
	wire oe_n, cs_n, os_n, pgm_n, vcc, vpp, idb, src_ready, busy, done, pass, fail;
	always #2 clk = ~clk;
	otp_program_host i_dut (.CLK(clk), .SYS_RST(rst), .CE(ce), .START_PROG(start_prog),
		.START_ID(start_id), .LAST_ADDR(16'h0000), .SRC_DATA(src_data), .SRC_VALID(src_valid),
		.SRC_READY(src_ready), .MEM_ADDR(addr), .MEM_DQ_OUT(dq_out), .MEM_DQ_OE_N(oe_n),
		.MEM_DQ_IN(dq_in), .CHIP_SEL_N(cs_n), .OUT_SEL_N(os_n), .PROGRAM_STROBE_N(pgm_n),
		.VCC_HIGH(vcc), .VPP_HIGH(vpp), .ID_MODE_ADDRESS_BIT(idb), .BUSY(busy), .DONE(done),
		.PASS(pass), .FAIL(fail), .MFR_CODE(mfr), .DEV_CODE(dev));
	otp_device_model i_model (.CLK(clk), .MEM_ADDR(addr), .MEM_DQ_OUT(dq_out),
		.MEM_DQ_OE_N(oe_n), .MEM_DQ_IN(dq_in), .CHIP_SEL_N(cs_n), .OUT_SEL_N(os_n),
		.PROGRAM_STROBE_N(pgm_n), .VPP_HIGH(vpp), .ID_MODE_ADDRESS_BIT(idb));
	task check(input [31:0] seen, input [31:0] exp);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			failures = failures + 1;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task print_verdict;
		$display("checks=%0d failures=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task run(input prog, input integer lim);
		@(posedge clk) #1;
		start_prog = prog;
		start_id = ~prog;
		@(posedge clk) #1;
		start_prog = 1'b0;
		start_id = 1'b0;
		check({31'h0, busy}, 32'h1);
		// A clock-enable gap early in the run must not disturb the sequence.
		repeat (4) @(posedge clk);
		#1 ce = 1'b0;
		repeat (20) @(posedge clk);
		#1 ce = 1'b1;
		for (k = 0; k < lim && done !== 1'b1; k = k + 1) @(posedge clk);
		if (done !== 1'b1) failures = failures + 1;
	endtask
	// Results are judged only when the verdict appears.
	initial forever begin
		@(posedge done) #1;
		note = notes.pop_front();
		if (note[32])
			check({mfr, dev}, note[31:0]);
		else
			check({30'h0, pass, fail}, note[31:0]);
	end
	initial begin
		#360000;
		failures = failures + 1;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge clk);
		#1 rst = 1'b0;
		notes.push_back({1'b1, 16'h005A, 16'h00C3});
		run(1'b0, 5000);
		// One word keeps the run short; the same word is replayed for read-back.
		#1 rnd = $random(seed);
		src_data = rnd[15:0];
		src_valid = 1'b1;
		for (k = 0; k < 2; k = k + 1) begin
			@(posedge clk);
			while (src_ready !== 1'b1) @(posedge clk);
		end
		#1 src_valid = 1'b0;
		notes.push_back({31'h0, 2'b10});
		run(1'b1, 80000);
		#8 check({16'h0, i_model.mem[0]}, {16'h0, src_data});
		print_verdict();
	end
endmodule
